/* File: hw/mvp_pkg.sv */
// Package: constants, register map and types of the measurement value post-processor
package mvp_pkg;
	// Data widths
	localparam int DW   = 18;
	localparam int OW   = 19;
	localparam int PW   = 10;
	localparam int IW   = 8;
	localparam int AW   = 6;
	localparam int NUMW = 34;
	localparam int DENW = 16;
	localparam int TO_W = 26;
	// Register offsets (byte addresses)
	localparam logic [AW-1:0] REG_TRIG = 6'h00;
	localparam logic [AW-1:0] REG_TCNT = 6'h04;
	localparam logic [AW-1:0] REG_CMD  = 6'h08;
	localparam logic [AW-1:0] REG_ROI  = 6'h0C;
	localparam logic [AW-1:0] REG_PROC = 6'h10;
	localparam logic [AW-1:0] REG_HOLD = 6'h14;
	localparam logic [AW-1:0] REG_AVG  = 6'h18;
	localparam logic [AW-1:0] REG_MAST = 6'h1C;
	localparam logic [AW-1:0] REG_STAT = 6'h20;
	localparam logic [AW-1:0] REG_OUT  = 6'h24;
	// Field positions
	localparam int TRIG_ACQ_BIT = 0;
	localparam int TRIG_OUT_BIT = 1;
	localparam int TRIG_SRC_LSB = 2;
	localparam int TRIG_POL_BIT = 4;
	localparam int CMD_SWTRIG   = 0;
	localparam int CMD_MASTER   = 1;
	localparam int CMD_UNMASTER = 2;
	localparam int CMD_CLRERR   = 3;
	localparam int ROI_HI_LSB   = 16;
	localparam int PROC_ERR_LSB = 2;
	localparam int AVG_N_LSB    = 16;
	// Trigger counts
	localparam int             TCNT_W       = 14;
	localparam logic [13:0]    TCNT_ENDLESS = 14'h3FFF;
	localparam logic [13:0]    TCNT_DEF     = 14'h0001;
	localparam int             TRIG_DELAY   = 3;
	// Error hold
	localparam int             HOLD_W   = 11;
	localparam logic [10:0]    HOLD_MAX = 11'h400;
	localparam logic [10:0]    HOLD_DEF = 11'h001;
	// Averaging limits and defaults
	localparam int             MOV_DEPTH = 128;
	localparam int             MOV_IW    = 7;
	localparam int             MED_DEPTH = 9;
	localparam logic [15:0]    MOV_MAX   = 16'h0080;
	localparam logic [15:0]    REC_MAX   = 16'h8000;
	localparam logic [15:0]    AVG_N_DEF = 16'h0009;
	// Region of interest defaults
	localparam logic [PW-1:0]  ROI_LO_DEF = 10'h000;
	localparam logic [PW-1:0]  ROI_HI_DEF = 10'h3FF;
	// Output values
	localparam logic [OW-1:0]  MASTER_MAX = 19'h7FFFE;
	localparam logic [OW-1:0]  ERR_VALUE  = 19'h7FFFF;
	// Master timeout
	localparam int MASTER_TO_S   = 2;
	localparam int CLK_HZ        = 25_000_000;
	localparam int MASTER_TO_DEF = MASTER_TO_S * CLK_HZ;
	// Enumerations
	typedef enum logic [1:0] {
		TSRC_LEVEL = 2'h0,
		TSRC_EDGE  = 2'h1,
		TSRC_SOFT  = 2'h2
	} mvp_tsrc_type;
	typedef enum logic [1:0] {
		PK_FIRST   = 2'h0,
		PK_HIGHEST = 2'h1,
		PK_LAST    = 2'h2
	} mvp_peak_type;
	typedef enum logic [1:0] {
		ERR_OUTPUT   = 2'h0,
		ERR_HOLD_INF = 2'h1,
		ERR_HOLD_CNT = 2'h2
	} mvp_err_type;
	typedef enum logic [1:0] {
		AVG_OFF       = 2'h0,
		AVG_MOVING    = 2'h1,
		AVG_RECURSIVE = 2'h2,
		AVG_MEDIAN    = 2'h3
	} mvp_avg_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_CALC = 2'b11,
		ST_FIN  = 2'b10
	} mvp_state_type;
endpackage : mvp_pkg

/* File: hw/mvp_divider.sv */
// Sequential restoring divider for the averaging stage
`timescale 1ns/1ps
module mvp_divider (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      reset_n_i,
	// Request
	input  wire logic                      start_i,
	input  wire logic [mvp_pkg::NUMW-1:0]  num_i,
	input  wire logic [mvp_pkg::DENW-1:0]  den_i,
	// Result
	output logic                           done_o,
	output logic [mvp_pkg::NUMW-1:0]       quot_o
);
	import mvp_pkg::*;

	logic [DENW:0]   rem_reg;
	logic [DENW-1:0] den_reg;
	logic [5:0]      cnt_reg;
	logic            busy_reg;
	wire  [DENW:0]   rem_sh;
	wire             fits;

	// Shift in next numerator bit and trial-subtract
	assign rem_sh = {rem_reg[DENW-1:0], quot_o[NUMW-1]};
	assign fits   = rem_sh >= {1'b0, den_reg};

	// One quotient bit per clock
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rem_reg  <= '0;
			den_reg  <= '0;
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			done_o   <= 1'b0;
			quot_o   <= '0;
		end else if (start_i) begin
			rem_reg  <= '0;
			den_reg  <= den_i;
			cnt_reg  <= 6'(NUMW);
			busy_reg <= 1'b1;
			done_o   <= 1'b0;
			quot_o   <= num_i;
		end else if (busy_reg) begin
			rem_reg  <= fits ? rem_sh - {1'b0, den_reg} : rem_sh;
			quot_o   <= {quot_o[NUMW-2:0], fits};
			cnt_reg  <= cnt_reg - 6'h01;
			busy_reg <= cnt_reg != 6'h01;
			done_o   <= cnt_reg == 6'h01;
		end else begin
			done_o   <= 1'b0;
		end
	end
endmodule : mvp_divider

/* File: hw/mvp_postproc.sv */
// Measurement value post-processor: gating, window, peak pick, errors, averaging, mastering
`timescale 1ns/1ps
module mvp_postproc #(
	parameter int MASTER_TO_CYC = mvp_pkg::MASTER_TO_DEF
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_n_i,
	// Register port
	input  wire logic [mvp_pkg::AW-1:0]   reg_addr_i,
	input  wire logic [31:0]              reg_wdata_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	output logic      [31:0]              reg_rdata_o,
	// Trigger pin
	input  wire logic                     trig_pin_i,
	// Peak stream of one line
	input  wire logic                     pk_valid_i,
	input  wire logic [mvp_pkg::PW-1:0]   pk_pos_i,
	input  wire logic [mvp_pkg::IW-1:0]   pk_int_i,
	input  wire logic [mvp_pkg::DW-1:0]   pk_dist_i,
	input  wire logic                     line_end_i,
	// Measurement output
	output logic                          out_valid_o,
	output logic      [mvp_pkg::OW-1:0]   out_value_o,
	output logic                          out_err_o,
	// Nonvolatile averaging settings
	input  wire logic                     nv_ok_i,
	input  wire logic [1:0]               nv_mode_i,
	input  wire logic [15:0]              nv_n_i,
	output logic                          nv_store_o,
	output logic      [1:0]               nv_mode_o,
	output logic      [15:0]              nv_n_o
);
	import mvp_pkg::*;

	// Validity of an averaging setting
	function automatic logic avg_ok(input logic [1:0] m, input logic [15:0] n);
		logic pow2;
		pow2 = (n & (n - 16'h0001)) == 16'h0000;
		case (mvp_avg_type'(m))
			AVG_MOVING:    avg_ok = n != 16'h0000 && n <= MOV_MAX && pow2;
			AVG_RECURSIVE: avg_ok = n != 16'h0000 && n <= REC_MAX;
			AVG_MEDIAN:    avg_ok = n == 16'h3 || n == 16'h5 || n == 16'h7 || n == 16'h9;
			default:       avg_ok = n != 16'h0000;
		endcase
	endfunction : avg_ok

	// Configuration registers
	logic              acq_en_reg, out_en_reg, trig_pol_reg, boot_reg;
	mvp_tsrc_type      trig_src_reg;
	logic [TCNT_W-1:0] tcnt_reg, remain_reg;
	logic [PW-1:0]     roi_lo_reg, roi_hi_reg;
	mvp_peak_type      peak_sel_reg;
	mvp_err_type       err_mode_reg;
	logic [HOLD_W-1:0] hold_lim_reg, hold_cnt_reg;
	mvp_avg_type       avg_mode_reg;
	logic [15:0]       avg_n_reg;
	logic [OW-1:0]     master_reg, last_reg;
	// Trigger and peak state
	logic [2:0]        sync_reg;
	logic              lvl_reg, act_prev_reg, ev_pend_reg;
	logic [TRIG_DELAY-1:0] gate_dly_reg;
	logic              best_vld_reg, vld_reg, rel_reg;
	logic [PW-1:0]     best_pos_reg;
	logic [IW-1:0]     best_int_reg;
	logic [DW-1:0]     raw_measurement_value_reg, avg_reg, rec_prev_reg, best_dist_reg;
	logic              rec_primed_reg, have_last_reg;
	// Averaging history
	logic [DW-1:0]     mov_buf [MOV_DEPTH];
	logic [DW-1:0]     med_reg [MED_DEPTH];
	logic [MOV_IW-1:0] mov_wp_reg;
	logic [DW+MOV_IW-1:0] mov_sum_reg;
	// Mastering state
	logic signed [OW:0] off_reg;
	logic              mst_act_reg, mst_pend_reg, st_to_reg, st_rng_reg;
	logic [TO_W-1:0]   to_cnt_reg;
	mvp_state_type     state_reg, state_next;
	logic [31:0]       rd_w;
	logic [DW-1:0]     med_val;
	logic [MED_DEPTH-1:0] med_hit;

	// Register write decode
	wire wr_trig = reg_wr_i && reg_addr_i == REG_TRIG;
	wire wr_tcnt = reg_wr_i && reg_addr_i == REG_TCNT;
	wire wr_cmd  = reg_wr_i && reg_addr_i == REG_CMD;
	wire wr_roi  = reg_wr_i && reg_addr_i == REG_ROI;
	wire wr_proc = reg_wr_i && reg_addr_i == REG_PROC;
	wire wr_hold = reg_wr_i && reg_addr_i == REG_HOLD;
	wire wr_avg  = reg_wr_i && reg_addr_i == REG_AVG;
	wire wr_mast = reg_wr_i && reg_addr_i == REG_MAST;
	wire cmd_sw  = wr_cmd && reg_wdata_i[CMD_SWTRIG];
	wire cmd_mst = wr_cmd && reg_wdata_i[CMD_MASTER];
	wire cmd_unm = wr_cmd && reg_wdata_i[CMD_UNMASTER];
	wire cmd_clr = wr_cmd && reg_wdata_i[CMD_CLRERR];
	wire [1:0]  avg_wm = reg_wdata_i[1:0];
	wire [15:0] avg_wn = reg_wdata_i[AVG_N_LSB +: 16];
	wire avg_wacc = wr_avg && avg_ok(avg_wm, avg_wn);
	wire boot_acc = boot_reg && nv_ok_i && avg_ok(nv_mode_i, nv_n_i);
	wire avg_clr  = avg_wacc || boot_acc;
	wire [HOLD_W-1:0] hold_w = reg_wdata_i[HOLD_W-1:0];
	wire [OW-1:0] mast_w = reg_wdata_i[OW-1:0];

	// Trigger level, edge and gate
	wire trig_on  = acq_en_reg || out_en_reg;
	wire trig_act = trig_pol_reg ? lvl_reg : ~lvl_reg;
	wire ev_now   = (trig_src_reg == TSRC_EDGE && trig_act && !act_prev_reg) ||
	                (trig_src_reg == TSRC_SOFT && cmd_sw);
	wire ev_any   = ev_pend_reg || ev_now;
	wire gate_now = !trig_on ? 1'b1 :
	                trig_src_reg == TSRC_LEVEL ? trig_act :
	                ev_any ? tcnt_reg != '0 : remain_reg != '0;
	wire gate_out = gate_dly_reg[TRIG_DELAY-1];
	wire proc_ok  = !acq_en_reg || gate_out;
	wire rel_now  = !trig_on || gate_out;
	wire take     = line_end_i && proc_ok && state_reg == ST_IDLE;
	wire hist_we  = take && best_vld_reg;

	// Peak selection inside the evaluation window
	wire in_win = pk_pos_i >= roi_lo_reg && pk_pos_i <= roi_hi_reg;
	wire better = !best_vld_reg ||
	              (peak_sel_reg == PK_FIRST ? pk_pos_i < best_pos_reg :
	               peak_sel_reg == PK_LAST ? pk_pos_i > best_pos_reg :
	               pk_int_i > best_int_reg);
	wire pk_take = pk_valid_i && in_win && better;

	// Moving window sum and oldest value
	wire mov_we = state_reg == ST_LOAD && vld_reg; // Oldest slot read before overwrite
	wire [DW-1:0] mov_old = mov_buf[mov_wp_reg - avg_n_reg[MOV_IW-1:0]];
	wire [DW+MOV_IW-1:0] moving_mean_sum = mov_sum_reg +
	     (DW+MOV_IW)'(raw_measurement_value_reg) - (DW+MOV_IW)'(mov_old);
	wire [3:0] med_n = avg_n_reg[3:0];
	wire [3:0] med_k = (med_n - 4'h1) >> 1;

	// Divider operands per averaging mode
	wire rec_on = avg_mode_reg == AVG_RECURSIVE && rec_primed_reg;
	wire [NUMW-1:0] rec_num = NUMW'(raw_measurement_value_reg) +
	     NUMW'(avg_n_reg - 16'h0001) * NUMW'(rec_prev_reg);
	wire [NUMW-1:0] div_num = rec_on ? rec_num :
	     avg_mode_reg == AVG_MOVING ? NUMW'(moving_mean_sum) :
	     avg_mode_reg == AVG_MEDIAN ? NUMW'(med_val) :
	     NUMW'(raw_measurement_value_reg);
	wire [DENW-1:0] div_den = (rec_on || avg_mode_reg == AVG_MOVING) ?
	     avg_n_reg : 16'h0001;
	wire div_start = state_reg == ST_LOAD && vld_reg;
	wire div_done;
	wire [NUMW-1:0] div_q;

	// Mastered value, clamped to the output range
	wire signed [OW:0] shifted = $signed({2'b00, avg_reg}) + off_reg;
	wire [OW-1:0] clamped = shifted < 0 ? '0 :
	     shifted > $signed({1'b0, MASTER_MAX}) ? MASTER_MAX : shifted[OW-1:0];
	wire hold_ok = have_last_reg && (err_mode_reg == ERR_HOLD_INF ||
	     (err_mode_reg == ERR_HOLD_CNT && hold_cnt_reg < hold_lim_reg));
	wire mst_to  = mst_pend_reg && to_cnt_reg == TO_W'(MASTER_TO_CYC - 1);
	wire fin     = state_reg == ST_FIN;
	wire rng_set = fin && !vld_reg && mst_pend_reg;

	mvp_divider u_div (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.start_i   (div_start),
		.num_i     (div_num),
		.den_i     (div_den),
		.done_o    (div_done),
		.quot_o    (div_q)
	);

	// Median by rank counting over the last N values
	genvar gi;
	for (gi = 0; gi < MED_DEPTH; gi++) begin : g_med
		always_comb begin
			logic [3:0] lt;
			logic [3:0] le;
			lt = '0;
			le = '0;
			for (int j = 0; j < MED_DEPTH; j++) begin
				if (4'(j) < med_n) begin
					if (med_reg[j] < med_reg[gi]) lt = lt + 4'h1;
					if (med_reg[j] <= med_reg[gi]) le = le + 4'h1;
				end
			end
			med_hit[gi] = 4'(gi) < med_n && lt <= med_k && le > med_k;
		end
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) med_reg[gi] <= '0;
			else if (avg_clr) med_reg[gi] <= '0;
			else if (hist_we) med_reg[gi] <= gi == 0 ? best_dist_reg : med_reg[gi - (gi > 0)];
		end
	end

	// Median pick, lowest index wins
	always_comb begin
		med_val = '0;
		for (int i = MED_DEPTH - 1; i >= 0; i--) begin
			if (med_hit[i]) med_val = med_reg[i];
		end
	end

	// Moving window storage
	for (gi = 0; gi < MOV_DEPTH; gi++) begin : g_mov
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) mov_buf[gi] <= '0;
			else if (avg_clr) mov_buf[gi] <= '0;
			else if (mov_we && mov_wp_reg == MOV_IW'(gi))
				mov_buf[gi] <= raw_measurement_value_reg;
		end
	end

	// Processing sequence
	always_comb begin
		case (state_reg)
			ST_IDLE: state_next = take ? ST_LOAD : ST_IDLE;
			ST_LOAD: state_next = vld_reg ? ST_CALC : ST_FIN;
			ST_CALC: state_next = div_done ? ST_FIN : ST_CALC;
			ST_FIN:  state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// Register read mux
	always_comb begin
		case (reg_addr_i)
			REG_TRIG: rd_w = {27'h0, trig_pol_reg, trig_src_reg, out_en_reg, acq_en_reg};
			REG_TCNT: rd_w = {18'h0, tcnt_reg};
			REG_ROI:  rd_w = {6'h0, roi_hi_reg, 6'h0, roi_lo_reg};
			REG_PROC: rd_w = {28'h0, err_mode_reg, peak_sel_reg};
			REG_HOLD: rd_w = {21'h0, hold_lim_reg};
			REG_AVG:  rd_w = {avg_n_reg, 14'h0, avg_mode_reg};
			REG_MAST: rd_w = {13'h0, master_reg};
			REG_STAT: rd_w = {26'h0, have_last_reg, gate_out, st_rng_reg, st_to_reg,
			                  mst_pend_reg, mst_act_reg};
			REG_OUT:  rd_w = {13'h0, last_reg};
			default:  rd_w = 32'h0;
		endcase
	end

	// Configuration and read data
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acq_en_reg   <= 1'b0;
			out_en_reg   <= 1'b0;
			trig_src_reg <= TSRC_LEVEL;
			trig_pol_reg <= 1'b1;
			tcnt_reg     <= TCNT_DEF;
			roi_lo_reg   <= ROI_LO_DEF;
			roi_hi_reg   <= ROI_HI_DEF;
			peak_sel_reg <= PK_HIGHEST;
			err_mode_reg <= ERR_OUTPUT;
			hold_lim_reg <= HOLD_DEF;
			master_reg   <= '0;
			reg_rdata_o  <= 32'h0;
		end else begin
			if (wr_trig) begin
				out_en_reg   <= reg_wdata_i[TRIG_OUT_BIT];
				acq_en_reg   <= reg_wdata_i[TRIG_ACQ_BIT] && !reg_wdata_i[TRIG_OUT_BIT];
				trig_src_reg <= mvp_tsrc_type'(reg_wdata_i[TRIG_SRC_LSB +: 2]);
				trig_pol_reg <= reg_wdata_i[TRIG_POL_BIT];
			end
			if (wr_tcnt) tcnt_reg <= reg_wdata_i[TCNT_W-1:0];
			if (wr_roi) begin
				roi_lo_reg <= reg_wdata_i[PW-1:0];
				roi_hi_reg <= reg_wdata_i[ROI_HI_LSB +: PW];
			end
			if (wr_proc) begin
				peak_sel_reg <= mvp_peak_type'(reg_wdata_i[1:0]);
				err_mode_reg <= mvp_err_type'(reg_wdata_i[PROC_ERR_LSB +: 2]);
			end
			if (wr_hold && hold_w != '0 && hold_w <= HOLD_MAX) hold_lim_reg <= hold_w;
			if (wr_mast) master_reg <= mast_w > MASTER_MAX ? MASTER_MAX : mast_w;
			reg_rdata_o <= reg_rd_i ? rd_w : 32'h0;
		end
	end

	// Averaging settings, loaded from nonvolatile store after reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_reg     <= 1'b1;
			avg_mode_reg <= AVG_MEDIAN;
			avg_n_reg    <= AVG_N_DEF;
			nv_store_o   <= 1'b0;
			nv_mode_o    <= AVG_MEDIAN;
			nv_n_o       <= AVG_N_DEF;
		end else begin
			boot_reg   <= 1'b0;
			nv_store_o <= avg_wacc;
			if (boot_acc) begin
				avg_mode_reg <= mvp_avg_type'(nv_mode_i);
				avg_n_reg    <= nv_n_i;
			end else if (avg_wacc) begin
				avg_mode_reg <= mvp_avg_type'(avg_wm);
				avg_n_reg    <= avg_wn;
				nv_mode_o    <= avg_wm;
				nv_n_o       <= avg_wn;
			end
		end
	end

	// Trigger pin synchroniser and gate timing
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_reg     <= 3'h0;
			lvl_reg      <= 1'b0;
			act_prev_reg <= 1'b0;
			ev_pend_reg  <= 1'b0;
			remain_reg   <= '0;
			gate_dly_reg <= '0;
		end else begin
			sync_reg     <= {sync_reg[1:0], trig_pin_i};
			lvl_reg      <= sync_reg[1] == sync_reg[2] ? sync_reg[2] : lvl_reg;
			act_prev_reg <= trig_act;
			ev_pend_reg  <= line_end_i ? 1'b0 : ev_any;
			if (wr_tcnt && reg_wdata_i[TCNT_W-1:0] == '0) remain_reg <= '0;
			else if (line_end_i && ev_any)
				remain_reg <= (tcnt_reg == TCNT_ENDLESS || tcnt_reg == '0) ?
				              tcnt_reg : tcnt_reg - 14'h0001; // event line is the first
			else if (line_end_i && remain_reg != '0 && remain_reg != TCNT_ENDLESS)
				remain_reg <= remain_reg - 14'h0001;
			if (line_end_i) gate_dly_reg <= {gate_dly_reg[TRIG_DELAY-2:0], gate_now};
		end
	end

	// Peak search over one line
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			best_vld_reg  <= 1'b0;
			best_pos_reg  <= '0;
			best_int_reg  <= '0;
			best_dist_reg <= '0;
		end else if (line_end_i) begin
			best_vld_reg <= 1'b0;
		end else if (pk_take) begin
			best_vld_reg  <= 1'b1;
			best_pos_reg  <= pk_pos_i;
			best_int_reg  <= pk_int_i;
			best_dist_reg <= pk_dist_i;
		end
	end

	// Line capture, moving sum and averaging result
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg      <= ST_IDLE;
			vld_reg        <= 1'b0;
			rel_reg        <= 1'b0;
			raw_measurement_value_reg <= '0;
			mov_wp_reg     <= '0;
			mov_sum_reg    <= '0;
			avg_reg        <= '0;
			rec_prev_reg   <= '0;
			rec_primed_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (take) begin
				vld_reg <= best_vld_reg;
				rel_reg <= rel_now;
				if (best_vld_reg) raw_measurement_value_reg <= best_dist_reg;
			end
			if (avg_clr) begin
				mov_wp_reg     <= '0;
				mov_sum_reg    <= '0;
				rec_primed_reg <= 1'b0;
			end else if (state_reg == ST_LOAD && vld_reg) begin
				mov_wp_reg  <= mov_wp_reg + 7'h01;
				mov_sum_reg <= moving_mean_sum;
			end
			if (state_reg == ST_CALC && div_done) begin
				avg_reg <= div_q[DW-1:0];
				if (avg_mode_reg == AVG_RECURSIVE) begin
					rec_prev_reg   <= div_q[DW-1:0];
					rec_primed_reg <= 1'b1;
				end
			end
		end
	end

	// Mastering, error handling and output stage
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			off_reg       <= '0;
			mst_act_reg   <= 1'b0;
			mst_pend_reg  <= 1'b0;
			to_cnt_reg    <= '0;
			st_to_reg     <= 1'b0;
			st_rng_reg    <= 1'b0;
			last_reg      <= '0;
			have_last_reg <= 1'b0;
			hold_cnt_reg  <= '0;
			out_valid_o   <= 1'b0;
			out_value_o   <= '0;
			out_err_o     <= 1'b0;
		end else begin
			out_valid_o <= fin && rel_reg;
			st_to_reg   <= mst_to || (st_to_reg && !cmd_clr);
			st_rng_reg  <= rng_set || (st_rng_reg && !cmd_clr);
			to_cnt_reg  <= mst_pend_reg ? to_cnt_reg + 26'h1 : '0;
			if (cmd_unm) begin
				mst_act_reg <= 1'b0;
				off_reg     <= '0;
			end
			if (cmd_mst) mst_pend_reg <= 1'b1;
			else if (mst_to || (fin && mst_pend_reg)) mst_pend_reg <= 1'b0;
			if (fin && vld_reg) begin
				if (mst_pend_reg) begin
					off_reg     <= $signed({1'b0, master_reg}) - $signed({2'b00, avg_reg});
					mst_act_reg <= 1'b1;
					out_value_o <= master_reg;
					last_reg    <= master_reg;
				end else begin
					out_value_o <= clamped;
					last_reg    <= clamped;
				end
				out_err_o     <= 1'b0;
				have_last_reg <= 1'b1;
				hold_cnt_reg  <= '0;
			end else if (fin) begin
				if (hold_ok) begin
					out_value_o  <= last_reg;
					out_err_o    <= 1'b0;
					hold_cnt_reg <= hold_cnt_reg + 11'h001;
				end else begin
					out_value_o <= ERR_VALUE;
					out_err_o   <= 1'b1;
				end
			end
		end
	end
endmodule : mvp_postproc

/* File: verification/mvp_postproc_monitor.sv */
// Checker on the post-processor output and averaging setting ports
`timescale 1ns/1ps
module mvp_postproc_monitor (
	// Clock, reset, register strobe
	input wire logic                    clk_i,
	input wire logic                    reset_n_i,
	input wire logic [mvp_pkg::AW-1:0]  reg_addr_i,
	input wire logic                    reg_wr_i,
	// Outputs under watch
	input wire logic                    out_valid_o,
	input wire logic [mvp_pkg::OW-1:0]  out_value_o,
	input wire logic                    out_err_o,
	input wire logic                    nv_store_o,
	input wire logic [1:0]              nv_mode_o,
	input wire logic [15:0]             nv_n_o
);
	import mvp_pkg::*;
	// One clock domain
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Output values
	a_err_value:
	assert property (out_valid_o && out_err_o |-> out_value_o == ERR_VALUE) else $error("bad err");
	a_value_range:
	assert property (out_valid_o && !out_err_o |-> out_value_o <= MASTER_MAX) else $error("range");
	a_valid_pulse:
	assert property (out_valid_o |=> !out_valid_o) else $error("valid not a pulse");
	// Averaging settings
	a_store_cause:
	assert property (nv_store_o |-> $past(reg_wr_i) && $past(reg_addr_i) == REG_AVG)
		else $error("store without write");
	a_moving_n:
	assert property (nv_mode_o == AVG_MOVING |-> $onehot(nv_n_o) && nv_n_o <= MOV_MAX)
		else $error("moving count");
	a_median_n:
	assert property (nv_mode_o == AVG_MEDIAN |-> nv_n_o inside {16'h3, 16'h5, 16'h7, 16'h9})
		else $error("median count");
	a_recursive_n:
	assert property (nv_mode_o == AVG_RECURSIVE |-> nv_n_o != 16'h0 && nv_n_o <= REC_MAX)
		else $error("recursive count");
	a_default_avg:
	assert property ($rose(reset_n_i) |-> nv_mode_o == AVG_MEDIAN && nv_n_o == AVG_N_DEF)
		else $error("default averaging");
endmodule : mvp_postproc_monitor

/* File: verification/mvp_host_model.sv */
// Host side capture of released measurement values
`timescale 1ns/1ps
module mvp_host_model (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// Device output
	input  wire logic                  out_valid_i,
	input  wire logic [mvp_pkg::OW-1:0] out_value_i,
	input  wire logic                  out_err_i,
	// Captured values
	output logic      [31:0]           count_o,
	output logic      [mvp_pkg::OW:0]  word_o
);
	import mvp_pkg::*;
	// Count each value and keep it with its error flag
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_o <= 32'h0;
			word_o <= '0;
		end else if (out_valid_i) begin
			count_o <= count_o + 32'h1;
			word_o <= {out_err_i, out_value_i};
		end
	end
endmodule : mvp_host_model

/* File: verification/testbench.sv */
// Self-checking bench for the measurement value post-processor
`timescale 1ns/1ps
module testbench;
	import mvp_pkg::*;
	logic clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, pk_valid_i = 0, line_end_i = 0;
	logic trig_pin_i = 0, nv_ok_i = 0, out_valid_o, out_err_o;
	logic [AW-1:0] reg_addr_i = '0;
	logic [31:0] reg_wdata_i = '0, reg_rdata_o, count;
	logic [PW-1:0] pk_pos_i = '0;
	logic [IW-1:0] pk_int_i = '0;
	logic [DW-1:0] pk_dist_i = '0;
	logic [OW-1:0] out_value_o;
	logic [OW:0] word;
	logic [1:0] nv_mode_i = 2'h0;
	logic [15:0] nv_n_i = 16'h0;
	int checks = 0, miscompares = 0;
	int mv[5] = '{1, 3, 6, 10, 14};
	// Clock
	always #20 clk_i = ~clk_i;
	mvp_postproc #(.MASTER_TO_CYC(200)) mvp_postproc_inst (.clk_i, .reset_n_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .trig_pin_i, .pk_valid_i, .pk_pos_i,
		.pk_int_i, .pk_dist_i, .line_end_i, .out_valid_o, .out_value_o, .out_err_o, .nv_ok_i,
		.nv_mode_i, .nv_n_i, .nv_store_o(), .nv_mode_o(), .nv_n_o());
	mvp_host_model mvp_host_model_inst (.clk_i, .reset_n_i, .out_valid_i(out_valid_o),
		.out_value_i(out_value_o), .out_err_i(out_err_o), .count_o(count), .word_o(word));
	// Compare tasks
	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t reg %h exp %h", $time, g, e);
		end
	endtask : cmp_reg
	task automatic cmp_out(input logic [OW:0] g, input logic [OW:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t out %h exp %h", $time, g, e);
		end
	endtask : cmp_out
	// Register access
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		cmp_reg(reg_rdata_o, e);
	endtask : rd
	// Line stream
	task automatic pk(input logic [PW-1:0] p, input logic [IW-1:0] i, input logic [DW-1:0] d);
		@(posedge clk_i);
		pk_valid_i <= 1'b1;
		pk_pos_i <= p;
		pk_int_i <= i;
		pk_dist_i <= d;
		@(posedge clk_i);
		pk_valid_i <= 1'b0;
	endtask : pk
	task automatic fin(input logic [OW-1:0] e, input logic ee);
		logic [31:0] c;
		int n;
		c = count;
		n = 0;
		@(posedge clk_i);
		line_end_i <= 1'b1;
		@(posedge clk_i);
		line_end_i <= 1'b0;
		while (count == c && n < 80) begin
			@(negedge clk_i);
			n++;
		end
		cmp_out(n < 80 ? word : 20'hXXXXX, {ee, e});
	endtask : fin
	// Line that must not be released
	task automatic quiet();
		logic [31:0] c;
		c = count;
		three();
		@(posedge clk_i);
		line_end_i <= 1'b1;
		@(posedge clk_i);
		line_end_i <= 1'b0;
		repeat (45) @(negedge clk_i);
		cmp_reg(count, c);
	endtask : quiet
	task automatic three();
		pk(10'h064, 8'h32, 18'h003E8);
		pk(10'h0C8, 8'h5A, 18'h007D0);
		pk(10'h12C, 8'h28, 18'h00BB8);
	endtask : three
	task automatic avg(input logic [DW-1:0] d, input logic [OW-1:0] e);
		pk(10'h100, 8'h80, d);
		fin(e, 1'b0);
	endtask : avg
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// Watchdog
	initial begin
		#1_000_000;
		miscompares++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rd(REG_TRIG, 32'h10);
		rd(REG_ROI, 32'h03FF0000);
		rd(REG_AVG, 32'h00090003);
		rd(6'h3C, 32'h0);
		wr(REG_TRIG, 32'h13);
		rd(REG_TRIG, 32'h12);
		wr(REG_AVG, 32'h00010000);
		trig_pin_i <= 1'b1;
		repeat (3) quiet();
		three();
		fin(19'h007D0, 1'b0);
		trig_pin_i <= 1'b0;
		wr(REG_TRIG, 32'h10);
		for (int k = 0; k < 3; k++) begin
			wr(REG_PROC, k);
			three();
			fin(19'h003E8 * (k + 1), 1'b0);
		end
		wr(REG_PROC, 32'h1);
		wr(REG_ROI, 32'h03FF00FA);
		three();
		fin(19'h00BB8, 1'b0);
		fin(ERR_VALUE, 1'b1);
		wr(REG_ROI, 32'h03FF0000);
		wr(REG_HOLD, 32'h2);
		wr(REG_PROC, 32'h9);
		three();
		fin(19'h007D0, 1'b0);
		repeat (2) fin(19'h007D0, 1'b0);
		fin(ERR_VALUE, 1'b1);
		three();
		fin(19'h007D0, 1'b0);
		fin(19'h007D0, 1'b0);
		wr(REG_PROC, 32'h1);
		wr(REG_AVG, 32'h00040001);
		for (int k = 1; k < 6; k++) avg(18'(4 * k), 19'(mv[k - 1]));
		wr(REG_AVG, 32'h00020002);
		avg(18'h0000A, 19'h0000A);
		avg(18'h00014, 19'h0000F);
		wr(REG_AVG, 32'h00030003);
		avg(18'h5, 19'h0);
		avg(18'h1, 19'h1);
		avg(18'h9, 19'h5);
		avg(18'h2, 19'h2);
		wr(REG_AVG, 32'h00010000);
		wr(REG_AVG, 32'h00030001);
		wr(REG_AVG, 32'h00010003);
		rd(REG_AVG, 32'h00010000);
		wr(REG_MAST, 32'h64);
		wr(REG_CMD, 32'h2);
		avg(18'h28, 19'h64);
		avg(18'h32, 19'h6E);
		wr(REG_MAST, 32'h0007FFFF);
		rd(REG_MAST, 32'h0007FFFE);
		wr(REG_AVG, 32'h80000002);
		wr(REG_AVG, 32'h80010002);
		rd(REG_AVG, 32'h80000002);
		nv_ok_i <= 1'b1;
		nv_mode_i <= 2'h1;
		nv_n_i <= 16'h0008;
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rd(REG_AVG, 32'h00080001);
		complete_run();
	end
endmodule : testbench
bind mvp_postproc mvp_postproc_monitor mvp_postproc_monitor_inst (.clk_i, .reset_n_i,
	.reg_addr_i, .reg_wr_i, .out_valid_o, .out_value_o, .out_err_o, .nv_store_o, .nv_mode_o,
	.nv_n_o);
